// ===== bench/sipo_host.sv
// Host model driving shift clock, serial data, strobe and enable pins
`timescale 1ns/1ps
module sipo_host (
  // Pacing clock
  input wire logic i_clk,
  // Pins toward the block
  output logic o_shift_clk,
  output logic o_ser_data,
  output logic o_strobe,
  output logic o_out_en
);
  // ====
  // Pin tasks; shift clock stands low between frames
  initial begin
    o_shift_clk = 1'b0;
    o_ser_data = 1'b0;
    o_strobe = 1'b0;
    o_out_en = 1'b0;
  end
  task automatic rise();
    @(posedge i_clk);
    o_shift_clk <= 1'b1;
    repeat (3) @(posedge i_clk);
    #1;
  endtask
  // Data moves at the fall, half a period ahead of the next rise
  task automatic fall(input logic nb);
    @(posedge i_clk);
    o_shift_clk <= 1'b0;
    o_ser_data <= nb;
    repeat (3) @(posedge i_clk);
    #1;
  endtask
  task automatic set_strobe(input logic v);
    @(posedge i_clk);
    o_strobe <= v;
    repeat (4) @(posedge i_clk);
    #1;
  endtask
  task automatic set_oe(input logic v);
    @(posedge i_clk);
    o_out_en <= v;
    repeat (3) @(posedge i_clk);
    #1;
  endtask
endmodule

// ===== bench/tb_top.sv
// Self-checking bench for the serial-in parallel-out latch block
`timescale 1ns/1ps
module tb_top;
  import sipo_pkg::*;
  // ====
  // Signals and expected state
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ready = 1'b0;
  logic sclk, sdat, stb, oe, casc, casc_dly, wvalid, wdrop;
  logic [7:0] par, par_oe, wdata;
  logic [7:0] sh = SHIFT_RST;
  logic [7:0] lat = LATCH_RST;
  logic [7:0] oe_m = 8'h00;
  logic stb_hi = 1'b0;
  logic [7:0] q[$];
  logic [7:0] corner [4] = '{8'h00, 8'hff, 8'h80, 8'h01};
  logic [31:0] rnd = 32'hb7581d13;
  int num_errors = 0;
  int n_tests = 0;
  int drops = 0;
  int exp_drops = 0;
  int cyc = 0;
  always #5 clk = ~clk;
  sipo_host sipo_host_inst (.i_clk(clk), .o_shift_clk(sclk), .o_ser_data(sdat),
    .o_strobe(stb), .o_out_en(oe));
  sipo_latch sipo_latch_inst (.I_CORE_CLK(clk), .I_RESET(rst), .I_SHIFT_CLK(sclk),
    .I_SER_DATA(sdat), .I_STROBE(stb), .I_OUT_EN(oe), .O_PAR_DATA(par), .O_PAR_OE(par_oe),
    .O_CASCADE(casc), .O_CASCADE_DLY(casc_dly), .O_WORD_VALID(wvalid),
    .I_WORD_READY(ready), .O_WORD_DATA(wdata), .O_WORD_DROP(wdrop));
  // ====
  // Helpers
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic logic [7:0] shift_in(input logic [7:0] s, input logic b);
    return {s[6:0], b};
  endfunction
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("errors %0d checks %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // ====
  // Monitors; drop is a one-cycle pulse, so it is counted at every edge
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      num_errors++;
      tally_and_finish();
    end
  end
  always @(posedge clk) begin
    if (wdrop === 1'b1) drops++;
  end
  always @(posedge clk) begin
    if (wvalid === 1'b1 && ready === 1'b1) begin
      chk("word", wdata, (q.size() > 0) ? q.pop_front() : 8'hxx);
    end
  end
  // ====
  // Pin sequences
  task automatic send_word(input logic [7:0] w);
    logic prev;
    sipo_host_inst.fall(w[7]);
    for (int i = 7; i >= 0; i--) begin
      prev = sh[7];
      sh = shift_in(sh, w[i]);
      if (stb_hi) lat = sh;
      sipo_host_inst.rise();
      chk("cascade", casc, sh[7]);
      chk("cascade_dly", casc_dly, prev);
      // Last fall leaves the inverse on the data pin between frames
      sipo_host_inst.fall((i > 0) ? w[i-1] : ~w[0]);
      chk("cascade_dly", casc_dly, sh[7]);
      chk("par_data", par & par_oe, lat & oe_m);
    end
  endtask
  task automatic strobe_to(input logic v);
    sipo_host_inst.set_strobe(v);
    stb_hi = v;
    if (v) lat = sh;
    chk("par_data", par & par_oe, lat & oe_m);
  endtask
  task automatic oe_to(input logic v);
    sipo_host_inst.set_oe(v);
    oe_m = {8{v}};
    chk("par_oe", par_oe, oe_m);
    chk("par_data", par & par_oe, lat & oe_m);
  endtask
  // ====
  // Main sequence: transparent shift, then held latch with the FIFO stalled
  initial begin
    logic [7:0] w;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    chk("par_oe", par_oe, 8'h00);
    oe_to(1'b1);
    strobe_to(1'b1);
    send_word(8'ha5);
    strobe_to(1'b0);
    q.push_back(sh);
    for (int k = 0; k < 12; k++) begin
      rnd = lfsr(rnd);
      w = (k < 4) ? corner[k] : rnd[15:8];
      oe_to(rnd[0]);
      send_word(w);
      strobe_to(1'b1);
      strobe_to(1'b0);
      if (q.size() < FIFO_DEPTH) q.push_back(sh);
      else exp_drops++;
    end
    chk("word_valid", {7'h00, wvalid}, 8'h01);
    chk("drops", 8'(drops), 8'(exp_drops));
    repeat (100) begin
      @(posedge clk);
      rnd = lfsr(rnd);
      ready <= rnd[0];
    end
    @(posedge clk);
    ready <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk("word_valid", {7'h00, wvalid}, 8'h00);
    chk("words_left", 8'(q.size()), 8'h00);
    tally_and_finish();
  end
endmodule

// ===== common/sipo_pkg.sv
// Package with constants for the serial-in parallel-out latch block
package sipo_pkg;
  // ==========================================================
  // Widths and depths
  localparam int STAGES = 8;
  localparam int FIFO_DEPTH = 8;
  localparam int SYNC_STAGES = 2;
  // ==========================================================
  // Reset values
  localparam logic [STAGES-1:0] SHIFT_RST = 8'h00;
  localparam logic [STAGES-1:0] LATCH_RST = 8'h00;
  // ==========================================================
  // Edge classification of a sampled pin
  typedef enum logic [1:0] {
    EDGE_NONE,
    EDGE_RISE,
    EDGE_FALL
  } sipo_edge_t;
endpackage

// ===== hdl/sipo_fifo.sv
// Parameterised FIFO with valid/ready on both sides
`timescale 1ns/1ps
module sipo_fifo
  import sipo_pkg::*;
#(
  parameter int WIDTH = STAGES,
  parameter int DEPTH = FIFO_DEPTH
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Fill side
  input wire logic i_valid,
  output logic o_ready,
  input wire logic [WIDTH-1:0] i_data,
  // Drain side
  output logic o_valid,
  input wire logic i_ready,
  output logic [WIDTH-1:0] o_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [AW:0] cnt_q, cnt_d;
  logic push, pop;

  function automatic logic [AW-1:0] inc_ptr(input logic [AW-1:0] p);
    inc_ptr = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  assign o_ready = (cnt_q != (AW+1)'(DEPTH));
  assign o_valid = (cnt_q != '0);
  assign o_data = mem_q[rd_q];
  assign push = i_valid & o_ready;
  assign pop = o_valid & i_ready;

  always_comb begin
    wr_d = push ? inc_ptr(wr_q) : wr_q;
    rd_d = pop ? inc_ptr(rd_q) : rd_q;
    cnt_d = cnt_q;
    if (push && !pop) begin
      cnt_d = cnt_q + 1'b1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
    end
  end

  // Storage has no reset; contents are only read when valid
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem_q[wr_q] <= i_data;
    end
  end
endmodule

// ===== hdl/sipo_latch.sv
// Eight-stage shift register with output latch, cascade outputs and FIFO tap
`timescale 1ns/1ps
// Notes on behaviour
// - Each rising shift clock edge loads serial data into stage 1, shifting others on.
// - Stage seven moves into stage eight; cascade output always equals stage eight.
// - Delayed cascade output copies cascade output at the next falling clock edge.
// - Latch bit N always takes its input from shift stage N.
// - While strobe is high the latch follows the register contents one core cycle late.
// - Strobe falling edge captures the contents; they hold while strobe stays low.
// - Parallel outputs drive the latch only while output enable is high, else float.
module sipo_latch
  import sipo_pkg::*;
#(
  parameter int WIDTH = STAGES,
  parameter int DEPTH = FIFO_DEPTH
) (
  // Clock and reset
  input wire logic I_CORE_CLK,
  input wire logic I_RESET,
  // Serial link pins from the host
  input wire logic I_SHIFT_CLK,
  input wire logic I_SER_DATA,
  input wire logic I_STROBE,
  input wire logic I_OUT_EN,
  // Parallel three-state outputs
  output logic [WIDTH-1:0] O_PAR_DATA,
  output logic [WIDTH-1:0] O_PAR_OE,
  // Cascade outputs
  output logic O_CASCADE,
  output logic O_CASCADE_DLY,
  // Captured-word stream, one word per strobe falling edge
  output logic O_WORD_VALID,
  input wire logic I_WORD_READY,
  output logic [WIDTH-1:0] O_WORD_DATA,
  output logic O_WORD_DROP
);
  // ==========================================================
  // Pin synchronisers
  // Every pin is asynchronous to the core clock. Two flops on each keep
  // metastability out of the decode, at the cost of a fixed latency.
  logic clk_lvl, clk_rise, clk_fall;
  logic dat_lvl, stb_lvl, stb_rise, stb_fall, oe_lvl;
  logic dat_meta_q, dat_q;
  logic oe_meta_q, oe_q;

  sipo_sync u_sync_clk (
    .i_clk(I_CORE_CLK),
    .i_rst(I_RESET),
    .i_async(I_SHIFT_CLK),
    .o_level(clk_lvl),
    .o_rise(clk_rise),
    .o_fall(clk_fall)
  );

  sipo_sync u_sync_stb (
    .i_clk(I_CORE_CLK),
    .i_rst(I_RESET),
    .i_async(I_STROBE),
    .o_level(stb_lvl),
    .o_rise(stb_rise),
    .o_fall(stb_fall)
  );

  // Data and enable need no edge detect; plain two-flop chains
  always_ff @(posedge I_CORE_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      dat_meta_q <= 1'b0;
      dat_q <= 1'b0;
      oe_meta_q <= 1'b0;
      oe_q <= 1'b0;
    end else begin
      dat_meta_q <= I_SER_DATA;
      dat_q <= dat_meta_q;
      oe_meta_q <= I_OUT_EN;
      oe_q <= oe_meta_q;
    end
  end
  assign dat_lvl = dat_q;
  assign oe_lvl = oe_q;

  // Edge class of the shift clock, used by the state update below
  function automatic sipo_edge_t classify(input logic rise, input logic fall);
    if (rise) begin
      classify = EDGE_RISE;
    end else if (fall) begin
      classify = EDGE_FALL;
    end else begin
      classify = EDGE_NONE;
    end
  endfunction

  // ==========================================================
  // Shift register and cascade outputs
  // The data pin passes two flops, as many as the clock, so data set up
  // before the shift clock edge is seen with it.
  // Limitation: a shift clock pulse shorter than one core cycle may be missed.
  logic [WIDTH-1:0] shift_q, shift_d;
  logic casc_dly_q, casc_dly_d;
  sipo_edge_t clk_edge;

  assign clk_edge = classify(clk_rise, clk_fall);

  always_comb begin
    shift_d = shift_q;
    casc_dly_d = casc_dly_q;
    case (clk_edge)
      EDGE_RISE: begin
        shift_d = {shift_q[WIDTH-2:0], dat_lvl};
      end
      EDGE_FALL: begin
        casc_dly_d = shift_q[WIDTH-1];
      end
      default: begin
        shift_d = shift_q;
      end
    endcase
  end

  always_ff @(posedge I_CORE_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      shift_q <= SHIFT_RST;
      casc_dly_q <= 1'b0;
    end else begin
      shift_q <= shift_d;
      casc_dly_q <= casc_dly_d;
    end
  end

  // Cascade pins are always driven, whatever strobe and enable do
  assign O_CASCADE = shift_q[WIDTH-1];
  assign O_CASCADE_DLY = casc_dly_q;

  // ==========================================================
  // Output latch
  // Transparency costs one core cycle: the latch follows the register
  // one cycle late rather than combinationally, so outputs are flopped.
  // The strobe fall takes one more copy, so a shift in the last
  // transparent cycle is still caught.
  logic [WIDTH-1:0] latch_q, latch_d;

  always_comb begin
    latch_d = latch_q;
    if (stb_lvl || stb_fall) begin
      latch_d = shift_q;
    end
  end

  always_ff @(posedge I_CORE_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      latch_q <= LATCH_RST;
    end else begin
      latch_q <= latch_d;
    end
  end

  // ==========================================================
  // Three-state parallel drivers
  // Enable is registered like the data, so both reach the pins on one edge.
  logic [WIDTH-1:0] oe_q_vec, oe_d_vec;

  always_comb begin
    oe_d_vec = oe_lvl ? {WIDTH{1'b1}} : '0;
  end

  always_ff @(posedge I_CORE_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      oe_q_vec <= '0;
    end else begin
      oe_q_vec <= oe_d_vec;
    end
  end

  assign O_PAR_DATA = latch_q;
  assign O_PAR_OE = oe_q_vec;

  // ==========================================================
  // Captured-word stream
  // A word is pushed on each strobe fall; a full FIFO drops the word and
  // raises a one-cycle drop pulse so the loss is visible.
  // The host cannot be held off, so there is no stall path: a slow
  // consumer loses words rather than corrupting the shift register.
  logic push_valid, push_ready;
  logic drop_q, drop_d;

  assign push_valid = stb_fall;

  always_comb begin
    drop_d = push_valid & ~push_ready;
  end

  always_ff @(posedge I_CORE_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      drop_q <= 1'b0;
    end else begin
      drop_q <= drop_d;
    end
  end
  assign O_WORD_DROP = drop_q;

  // The queue takes the register itself, which equals the captured word.
  sipo_fifo #(
    .WIDTH(WIDTH),
    .DEPTH(DEPTH)
  ) u_fifo (
    .i_clk(I_CORE_CLK),
    .i_rst(I_RESET),
    .i_valid(push_valid),
    .o_ready(push_ready),
    .i_data(shift_q),
    .o_valid(O_WORD_VALID),
    .i_ready(I_WORD_READY),
    .o_data(O_WORD_DATA)
  );

  // ==========================================================
  // Assertions
  // Each check sits one core edge behind the synchronised pin event that
  // causes it; pin-level latency is left to the bench.
  a_shift_on_rise: assert property (@(posedge I_CORE_CLK) disable iff (I_RESET)
    clk_rise |=> shift_q == {$past(shift_q[WIDTH-2:0]), $past(dat_lvl)})
    else $error("shift register did not advance on clock rise");

  a_shift_hold: assert property (@(posedge I_CORE_CLK) disable iff (I_RESET)
    !clk_rise |=> $stable(shift_q))
    else $error("shift register changed without clock rise");

  a_cascade_last: assert property (@(posedge I_CORE_CLK) disable iff (I_RESET)
    clk_rise |=> O_CASCADE == $past(shift_q[WIDTH-2]))
    else $error("cascade output is not old stage seven");

  a_cascade_dly: assert property (@(posedge I_CORE_CLK) disable iff (I_RESET)
    clk_fall |=> O_CASCADE_DLY == $past(O_CASCADE))
    else $error("delayed cascade missed falling edge");

  a_cascade_dly_hold: assert property (@(posedge I_CORE_CLK) disable iff (I_RESET)
    !clk_fall |=> $stable(O_CASCADE_DLY))
    else $error("delayed cascade changed without falling edge");

  a_latch_transp: assert property (@(posedge I_CORE_CLK) disable iff (I_RESET)
    stb_lvl |=> O_PAR_DATA == $past(shift_q))
    else $error("latch not transparent while strobe high");

  a_latch_bitmap: assert property (@(posedge I_CORE_CLK) disable iff (I_RESET)
    stb_fall |=> O_PAR_DATA == $past(shift_q))
    else $error("latch bit does not follow its stage");

  a_latch_hold: assert property (@(posedge I_CORE_CLK) disable iff (I_RESET)
    (!stb_lvl && !stb_fall) |=> $stable(O_PAR_DATA))
    else $error("latch changed while strobe low");

  a_out_drive: assert property (@(posedge I_CORE_CLK) disable iff (I_RESET)
    oe_lvl |=> O_PAR_OE == {WIDTH{1'b1}})
    else $error("parallel outputs not driven while enable high");

  a_out_float: assert property (@(posedge I_CORE_CLK) disable iff (I_RESET)
    !oe_lvl |=> O_PAR_OE == '0)
    else $error("parallel outputs driven while enable low");

  a_cascade_hold: assert property (@(posedge I_CORE_CLK) disable iff (I_RESET)
    !clk_rise |=> $stable(O_CASCADE))
    else $error("cascade output changed without clock rise");

  a_latch_oe_free: assert property (@(posedge I_CORE_CLK) disable iff (I_RESET)
    (stb_lvl && !oe_lvl) |=> O_PAR_DATA == $past(shift_q))
    else $error("latch stopped following while outputs float");

  // Shifting and the delayed cascade must not wait on strobe or enable
  a_shift_free: assert property (@(posedge I_CORE_CLK) disable iff (I_RESET)
    (clk_rise && !stb_lvl && !oe_lvl) |=> O_CASCADE == $past(shift_q[WIDTH-2]))
    else $error("shift stalled while strobe and enable low");

  a_dly_free: assert property (@(posedge I_CORE_CLK) disable iff (I_RESET)
    (clk_fall && !oe_lvl) |=> O_CASCADE_DLY == $past(O_CASCADE))
    else $error("delayed cascade stalled while enable low");

  // Every strobe fall either queues the captured word or flags its loss
  a_word_push: assert property (@(posedge I_CORE_CLK) disable iff (I_RESET)
    (stb_fall && push_ready) |=> O_WORD_VALID)
    else $error("captured word was not queued");

  a_word_lost: assert property (@(posedge I_CORE_CLK) disable iff (I_RESET)
    (stb_fall && !push_ready) |=> O_WORD_DROP)
    else $error("full queue did not flag a lost word");

  a_drop_single: assert property (@(posedge I_CORE_CLK) disable iff (I_RESET)
    O_WORD_DROP |=> !O_WORD_DROP)
    else $error("drop pulse longer than one cycle");

  a_word_hold: assert property (@(posedge I_CORE_CLK) disable iff (I_RESET)
    (O_WORD_VALID && !I_WORD_READY) |=> (O_WORD_VALID && $stable(O_WORD_DATA)))
    else $error("queued word changed before it was taken");

  c_shift_full: cover property (@(posedge I_CORE_CLK) disable iff (I_RESET)
    clk_rise && stb_lvl);
  c_strobe_capture: cover property (@(posedge I_CORE_CLK) disable iff (I_RESET)
    stb_fall && oe_lvl);
  c_cascade_delay: cover property (@(posedge I_CORE_CLK) disable iff (I_RESET)
    clk_fall && O_CASCADE != O_CASCADE_DLY);
  c_fifo_drop: cover property (@(posedge I_CORE_CLK) disable iff (I_RESET) O_WORD_DROP);
  c_out_float: cover property (@(posedge I_CORE_CLK) disable iff (I_RESET) clk_rise && !oe_lvl);
endmodule

// ===== hdl/sipo_sync.sv
// Two-flop synchroniser with edge detection on the synchronised level
`timescale 1ns/1ps
module sipo_sync
  import sipo_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Asynchronous level in
  input wire logic i_async,
  // Synchronised level and edges
  output logic o_level,
  output logic o_rise,
  output logic o_fall
);
  logic meta_q, meta_d;
  logic sync_q, sync_d;
  logic last_q, last_d;

  always_comb begin
    meta_d = i_async;
    sync_d = meta_q;
    last_d = sync_q;
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      last_q <= 1'b0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
      last_q <= last_d;
    end
  end

  // Edges are taken only from the second flop onward
  assign o_level = sync_q;
  assign o_rise = sync_q & ~last_q;
  assign o_fall = ~sync_q & last_q;
endmodule
